/* File: tcf_regs.sv */
// Timer width, interrupt level, command/flag and buffer-valid registers
`timescale 1ns/10ps
module tcf_regs #(
	parameter int unsigned ADDR_W = 8
) (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         srst,
	// Register port
	input  wire logic [ADDR_W-1:0]            addr,
	input  wire logic [7:0]                   wr_data,
	input  wire logic                         wr_strobe,
	input  wire logic                         rd_strobe,
	output logic      [7:0]                   rd_data,
	// Counting engine status
	input  wire logic                         tc_off,
	input  wire logic                         capture_mode,
	input  wire logic [2:0]                   wave_mode,
	input  wire logic                         at_top,
	input  wire logic                         at_bottom,
	input  wire logic                         count_tick,
	input  wire logic                         hw_dir_valid,
	input  wire logic                         hw_dir,
	input  wire logic                         qdec_index,
	// Buffer and capture events
	input  wire logic                         per_buf_written,
	input  wire logic [tcf_pkg::N_CH-1:0]     ch_buf_written,
	input  wire logic [tcf_pkg::N_CH-1:0]     capture_event,
	input  wire logic [tcf_pkg::N_CH-1:0]     ch_irq_flag_clear,
	// Interrupt flags from the flag register
	input  wire logic                         err_flag,
	input  wire logic                         wrap_flag,
	input  wire logic [tcf_pkg::N_CH-1:0]     ch_irq_flag,
	// Control outputs
	output logic      [1:0]                   width_sel,
	output logic                              count_down,
	output logic      [tcf_pkg::CNT_W-1:0]    count_value,
	output logic                              buffer_transfer,
	output logic                              timer_restart,
	output logic                              timer_hard_reset,
	output logic      [tcf_pkg::N_LVL-1:0]    irq_req
);
	import tcf_pkg::*;

	typedef struct packed {
		logic [1:0]      width_sel;
		logic [3:0]      irq_a;
		logic [7:0]      irq_b;
		logic            qidx;
		logic            lock;
		logic            dir;
		logic [N_CH:0]   bv;
		logic            xfer;
		logic            restart;
		logic            hard;
		logic [7:0]      rd_data;
	} tcf_reg_state_t;

	tcf_reg_state_t st;
	tcf_reg_state_t next_st;

	logic       wr_width;
	logic       wr_irq_a;
	logic       wr_irq_b;
	logic       wr_fclr;
	logic       wr_fset;
	logic       wr_gclr;
	logic       wr_gset;
	logic [1:0] cmd;
	logic       update_event;
	logic       force_upd;
	logic       xfer_now;
	logic       leave_zero;
	logic [7:0] f_view;
	logic [7:0] g_view;

	// Address decode and command field
	assign wr_width = wr_strobe && addr == ADDR_W'(OFF_WIDTH);
	assign wr_irq_a = wr_strobe && addr == ADDR_W'(OFF_IRQ_A);
	assign wr_irq_b = wr_strobe && addr == ADDR_W'(OFF_IRQ_B);
	assign wr_fclr  = wr_strobe && addr == ADDR_W'(OFF_F_CLR);
	assign wr_fset  = wr_strobe && addr == ADDR_W'(OFF_F_SET);
	assign wr_gclr  = wr_strobe && addr == ADDR_W'(OFF_G_CLR);
	assign wr_gset  = wr_strobe && addr == ADDR_W'(OFF_G_SET);
	assign cmd      = wr_fset ? wr_data[F_CMD_LO +: 2] : CMD_NONE;

	// Update moment depends on the waveform mode
	assign update_event = (wave_mode == WG_NORMAL || wave_mode == WG_FRQ) ? at_top
		: at_bottom;
	assign force_upd = cmd == CMD_UPDATE;
	// Lock only bites outside capture; a forced update obeys the lock too
	assign xfer_now = (update_event || force_upd) && (!st.lock || capture_mode);

	// Read views; command bits are never stored, so they read zero
	assign f_view = {3'h0, st.qidx, 2'h0, st.lock, st.dir};
	assign g_view = {3'h0, st.bv};

	// Next state of all registers
	always_comb begin
		next_st = st;
		next_st.xfer    = xfer_now;
		next_st.restart = cmd == CMD_RESTART;
		next_st.hard    = cmd == CMD_RESET && tc_off;
		next_st.rd_data = RST_REG;

		// Plain read/write registers; reserved bits are not stored
		if (wr_width) begin
			next_st.width_sel = wr_data[1:0];
		end
		if (wr_irq_a) begin
			next_st.irq_a = wr_data[3:0];
		end
		if (wr_irq_b) begin
			next_st.irq_b = wr_data;
		end

		// Direction: hardware first, a software write in the same cycle wins
		if (hw_dir_valid) begin
			next_st.dir = hw_dir;
		end
		if (wr_fclr && wr_data[F_DIR]) begin
			next_st.dir = 1'h0;
		end
		if (wr_fset && wr_data[F_DIR]) begin
			next_st.dir = 1'h1;
		end

		// Lock bit
		if (wr_fclr && wr_data[F_LOCK]) begin
			next_st.lock = 1'h0;
		end
		if (wr_fset && wr_data[F_LOCK]) begin
			next_st.lock = 1'h1;
		end

		// Index flag: clears first, so an index in the same cycle survives
		if (leave_zero || (wr_fclr && wr_data[F_QIDX])) begin
			next_st.qidx = 1'h0;
		end
		if (qdec_index || (wr_fset && wr_data[F_QIDX])) begin
			next_st.qidx = 1'h1;
		end

		// Period buffer valid; a new write beats the update that clears it
		if (xfer_now || (wr_gclr && wr_data[G_PER])) begin
			next_st.bv[G_PER] = 1'h0;
		end
		if (per_buf_written || (wr_gset && wr_data[G_PER])) begin
			next_st.bv[G_PER] = 1'h1;
		end

		// Channel buffer valid bits change their cause in capture operation
		for (int i = 0; i < N_CH; i++) begin
			if ((capture_mode ? ch_irq_flag_clear[i] : xfer_now)
				|| (wr_gclr && wr_data[G_CH_LO + i])) begin
				next_st.bv[G_CH_LO + i] = 1'h0;
			end
			if ((capture_mode ? capture_event[i] : ch_buf_written[i])
				|| (wr_gset && wr_data[G_CH_LO + i])) begin
				next_st.bv[G_CH_LO + i] = 1'h1;
			end
		end

		// Hard reset returns every register to its reset value
		if (next_st.hard) begin
			next_st.width_sel = WIDTH_NORMAL;
			next_st.irq_a     = '0;
			next_st.irq_b     = '0;
			next_st.qidx      = 1'h0;
			next_st.lock      = 1'h0;
			next_st.dir       = 1'h0;
			next_st.bv        = '0;
			next_st.xfer      = 1'h0;
		end

		// Read data stand for exactly one cycle after the strobe
		if (rd_strobe) begin
			if (addr == ADDR_W'(OFF_WIDTH)) begin
				next_st.rd_data = {6'h00, st.width_sel};
			end else if (addr == ADDR_W'(OFF_IRQ_A)) begin
				next_st.rd_data = {4'h0, st.irq_a};
			end else if (addr == ADDR_W'(OFF_IRQ_B)) begin
				next_st.rd_data = st.irq_b;
			end else if (addr == ADDR_W'(OFF_F_CLR) || addr == ADDR_W'(OFF_F_SET)) begin
				next_st.rd_data = f_view;
			end else if (addr == ADDR_W'(OFF_G_CLR) || addr == ADDR_W'(OFF_G_SET)) begin
				next_st.rd_data = g_view;
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Counter core, cleared by restart and hard reset pulses
	tcf_counter u_counter (
		.clk         (clk),
		.srst        (srst),
		.tick        (count_tick),
		.count_down  (st.dir),
		.width_sel   (st.width_sel),
		.clear       (st.restart || st.hard),
		.count_value (count_value),
		.leave_zero  (leave_zero)
	);

	// Priority requests toward the interrupt controller
	tcf_irq_level u_irq (
		.clk       (clk),
		.srst      (srst),
		.src_flag  ({ch_irq_flag, err_flag, wrap_flag}),
		.src_level ({st.irq_b, st.irq_a[IRQA_ERR_LO +: 2], st.irq_a[IRQA_WRAP_LO +: 2]}),
		.irq_req   (irq_req)
	);

	assign width_sel        = st.width_sel;
	assign count_down       = st.dir;
	assign buffer_transfer  = st.xfer;
	assign timer_restart    = st.restart;
	assign timer_hard_reset = st.hard;
	assign rd_data          = st.rd_data;

	// Checks on the registered behaviour
	default clocking tcf_cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence s_flag_read;
		rd_strobe && (addr == ADDR_W'(OFF_F_CLR) || addr == ADDR_W'(OFF_F_SET));
	endsequence

	sequence s_reset_cmd_off;
		wr_fset && wr_data[F_CMD_LO +: 2] == CMD_RESET && tc_off;
	endsequence

	property p_cmd_reads_zero;
		s_flag_read |=> rd_data[F_CMD_LO +: 2] == 2'h0;
	endproperty
	a_cmd_reads_zero: assert property (p_cmd_reads_zero)
		else $error("command bits read back nonzero");

	property p_dual_read;
		s_flag_read |=> rd_data[F_LOCK] == $past(st.lock) && rd_data[F_DIR] == $past(st.dir);
	endproperty
	a_dual_read: assert property (p_dual_read)
		else $error("dual-mapped read differs from register");

	property p_lock_set_clear;
		(wr_fset && wr_data[F_LOCK] && cmd != CMD_RESET) ##1 (wr_fclr && wr_data[F_LOCK])
			|=> st.lock == 1'h0 ##0 $past(st.lock, 1);
	endproperty
	a_lock_set_clear: assert property (p_lock_set_clear)
		else $error("set then clear of lock misbehaved");

	property p_lock_blocks;
		st.lock && !capture_mode |=> !buffer_transfer;
	endproperty
	a_lock_blocks: assert property (p_lock_blocks)
		else $error("transfer while locked");

	property p_capture_ignores_lock;
		capture_mode && (update_event || force_upd) && !(cmd == CMD_RESET && tc_off)
			|=> buffer_transfer;
	endproperty
	a_capture_ignores_lock: assert property (p_capture_ignores_lock)
		else $error("lock blocked a transfer in capture");

	property p_update_clears_per;
		xfer_now && !per_buf_written && !wr_gset |=> !st.bv[G_PER];
	endproperty
	a_update_clears_per: assert property (p_update_clears_per)
		else $error("period valid not cleared on update");

	property p_buf_write_sets;
		ch_buf_written[0] && !capture_mode && !next_st.hard |=> st.bv[G_CH_LO];
	endproperty
	a_buf_write_sets: assert property (p_buf_write_sets)
		else $error("channel valid not set on buffer write");

	property p_capture_sets;
		capture_mode && capture_event[1] && !next_st.hard |=> st.bv[G_CH_LO + 1];
	endproperty
	a_capture_sets: assert property (p_capture_sets)
		else $error("channel valid not set on capture");

	// A second reset command right behind the first legally stretches the pulse
	property p_hard_reset;
		s_reset_cmd_off ##1 !(wr_fset && wr_data[F_CMD_LO +: 2] == CMD_RESET)
			|-> timer_hard_reset && width_sel == WIDTH_NORMAL ##1 !timer_hard_reset;
	endproperty
	a_hard_reset: assert property (p_hard_reset)
		else $error("hard reset not taken while off");

	property p_hard_reset_ignored;
		wr_fset && wr_data[F_CMD_LO +: 2] == CMD_RESET && !tc_off |=> !timer_hard_reset;
	endproperty
	a_hard_reset_ignored: assert property (p_hard_reset_ignored)
		else $error("hard reset taken while running");

	property p_upper_zero;
		width_sel == WIDTH_UPPER_ZERO && $past(width_sel == WIDTH_UPPER_ZERO)
			|-> count_value[CNT_W-1:BYTE_W] == '0;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("upper byte not zero");

	property p_hw_dir;
		hw_dir_valid && !(wr_fset || wr_fclr) && !next_st.hard |=> count_down == $past(hw_dir);
	endproperty
	a_hw_dir: assert property (p_hw_dir)
		else $error("direction does not follow hardware");

	property p_index_sets;
		qdec_index && !next_st.hard |=> st.qidx;
	endproperty
	a_index_sets: assert property (p_index_sets)
		else $error("index flag not set");

endmodule // tcf_regs

/* File: tcf_pkg.sv */
// Constants shared by the timer control and flag register block
package tcf_pkg;

	// Register offsets on the byte-wide register port
	localparam logic [7:0] OFF_WIDTH = 8'h04;
	localparam logic [7:0] OFF_IRQ_A = 8'h06;
	localparam logic [7:0] OFF_IRQ_B = 8'h07;
	localparam logic [7:0] OFF_F_CLR = 8'h08;
	localparam logic [7:0] OFF_F_SET = 8'h09;
	localparam logic [7:0] OFF_G_CLR = 8'h0a;
	localparam logic [7:0] OFF_G_SET = 8'h0b;

	// Reset value of every register in the block
	localparam logic [7:0] RST_REG = 8'h00;

	// Counter width select codes
	localparam logic [1:0] WIDTH_NORMAL     = 2'h0;
	localparam logic [1:0] WIDTH_UPPER_ZERO = 2'h1;
	localparam logic [1:0] WIDTH_DUAL8      = 2'h2;

	// Software command codes
	localparam logic [1:0] CMD_NONE    = 2'h0;
	localparam logic [1:0] CMD_UPDATE  = 2'h1;
	localparam logic [1:0] CMD_RESTART = 2'h2;
	localparam logic [1:0] CMD_RESET   = 2'h3;

	// Interrupt level codes
	localparam logic [1:0] LVL_OFF = 2'h0;

	// Waveform modes that update at TOP; all others update at BOTTOM
	localparam logic [2:0] WG_NORMAL = 3'h0;
	localparam logic [2:0] WG_FRQ    = 3'h1;

	// Field positions
	localparam int unsigned F_DIR    = 0;
	localparam int unsigned F_LOCK   = 1;
	localparam int unsigned F_CMD_LO = 2;
	localparam int unsigned F_QIDX   = 4;
	localparam int unsigned G_PER    = 0;
	localparam int unsigned G_CH_LO  = 1;
	localparam int unsigned IRQA_WRAP_LO = 0;
	localparam int unsigned IRQA_ERR_LO  = 2;

	// Sizes
	localparam int unsigned CNT_W  = 16;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned N_CH   = 4;
	localparam int unsigned N_SRC  = 6;
	localparam int unsigned N_LVL  = 3;

endpackage

/* File: tcf_counter.sv */
// Counter core with normal, upper-byte-zeroed and dual 8-bit modes
`timescale 1ns/10ps
module tcf_counter (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       srst,
	// Control
	input  wire logic                       tick,
	input  wire logic                       count_down,
	input  wire logic [1:0]                 width_sel,
	input  wire logic                       clear,
	// Status
	output logic      [tcf_pkg::CNT_W-1:0]  count_value,
	output logic                            leave_zero
);
	import tcf_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             leave_zero;
	} tcf_cnt_state_t;

	tcf_cnt_state_t st;
	tcf_cnt_state_t next_st;

	// One step of an 8-bit half, wrapping within the byte
	function automatic logic [BYTE_W-1:0] tcf_step8(input logic [BYTE_W-1:0] v,
		input logic down);
		tcf_step8 = down ? BYTE_W'(v - 1'h1) : BYTE_W'(v + 1'h1);
	endfunction

	// Next count; clear wins over a tick
	always_comb begin
		next_st = st;
		next_st.leave_zero = tick && !clear && (st.cnt == '0);
		if (clear) begin
			next_st.cnt = '0;
		end else if (tick) begin
			if (width_sel == WIDTH_DUAL8) begin
				// Halves run alone, no carry between them
				next_st.cnt = {tcf_step8(st.cnt[CNT_W-1:BYTE_W], count_down),
					tcf_step8(st.cnt[BYTE_W-1:0], count_down)};
			end else begin
				next_st.cnt = count_down ? CNT_W'(st.cnt - 1'h1) : CNT_W'(st.cnt + 1'h1);
			end
		end
		// Upper byte forced low on every cycle in this mode
		if (width_sel == WIDTH_UPPER_ZERO) begin
			next_st.cnt[CNT_W-1:BYTE_W] = '0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign count_value = st.cnt;
	assign leave_zero  = st.leave_zero;

endmodule // tcf_counter

/* File: tcf_irq_level.sv */
// Interrupt level decode: each enabled source raises a low, medium or high request
`timescale 1ns/10ps
module tcf_irq_level (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         srst,
	// Sources and their two-bit levels
	input  wire logic [tcf_pkg::N_SRC-1:0]    src_flag,
	input  wire logic [2*tcf_pkg::N_SRC-1:0]  src_level,
	// Requests: bit 0 low, bit 1 medium, bit 2 high
	output logic      [tcf_pkg::N_LVL-1:0]    irq_req
);
	import tcf_pkg::*;

	typedef struct packed {
		logic [N_LVL-1:0] req;
	} tcf_irq_state_t;

	tcf_irq_state_t st;
	tcf_irq_state_t next_st;

	// Level 00 means the source is masked
	always_comb begin
		next_st.req = '0;
		for (int i = 0; i < N_SRC; i++) begin
			if (src_flag[i] && src_level[2*i +: 2] != LVL_OFF) begin
				next_st.req[src_level[2*i +: 2] - 2'h1] = 1'h1;
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign irq_req = st.req;

endmodule // tcf_irq_level

/* File: tcf_regs_tb.sv */
// Self-checking testbench for the timer control, flag and buffer-valid register block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tcf_regs_tb;
	import tcf_pkg::*;

	// Design signals
	logic                clk;
	logic                srst;
	logic [7:0]          addr;
	logic [7:0]          wr_data;
	logic                wr_strobe;
	logic                rd_strobe;
	logic [7:0]          rd_data;
	logic                tc_off;
	logic                capture_mode;
	logic [2:0]          wave_mode;
	logic                at_top;
	logic                at_bottom;
	logic                count_tick;
	logic                hw_dir_valid;
	logic                hw_dir;
	logic                qdec_index;
	logic                per_buf_written;
	logic [N_CH-1:0]     ch_buf_written;
	logic [N_CH-1:0]     capture_event;
	logic [N_CH-1:0]     ch_irq_flag_clear;
	logic                err_flag;
	logic                wrap_flag;
	logic [N_CH-1:0]     ch_irq_flag;
	logic [1:0]          width_sel;
	logic                count_down;
	logic [CNT_W-1:0]    count_value;
	logic                buffer_transfer;
	logic                timer_restart;
	logic                timer_hard_reset;
	logic [N_LVL-1:0]    irq_req;

	// Bench bookkeeping
	int                  err_total;
	int                  n_tests;
	logic [7:0]          rv;
	logic [3:0]          nbt;
	logic [3:0]          nrs;
	logic [3:0]          nhr;
	// Rows: write flag, write address, write data, read address, expected read
	logic [39:0]         rows [18] = '{
		40'h00_00_00_04_00, 40'h00_00_00_06_00, 40'h00_00_00_07_00, 40'h00_00_00_08_00,
		40'h00_00_00_09_00, 40'h00_00_00_0a_00, 40'h00_00_00_0b_00, 40'h01_04_02_04_02,
		40'h01_06_0d_06_0d, 40'h01_07_e4_07_e4, 40'h01_09_13_09_13, 40'h00_00_00_08_13,
		40'h01_08_01_09_12, 40'h01_08_12_08_00, 40'h01_0b_1f_0a_1f, 40'h01_0a_05_0b_1a,
		40'h01_05_55_05_00, 40'h00_00_00_04_02};
	// Interrupt rows: err, wrap, channel flags, expected request
	logic [8:0]          irows [6] = '{9'b1_0_0000_100, 9'b0_1_0000_001, 9'b0_0_0001_000,
		9'b0_0_0100_010, 9'b0_0_1000_100, 9'b0_0_0010_001};
	logic [11:0]         cexp [4] = '{12'h000, 12'h100, 12'h010, 12'h000};

	tcf_regs #(.ADDR_W(8)) tcf_regs_i (.clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .tc_off(tc_off),
		.capture_mode(capture_mode), .wave_mode(wave_mode), .at_top(at_top),
		.at_bottom(at_bottom), .count_tick(count_tick), .hw_dir_valid(hw_dir_valid),
		.hw_dir(hw_dir), .qdec_index(qdec_index), .per_buf_written(per_buf_written),
		.ch_buf_written(ch_buf_written), .capture_event(capture_event),
		.ch_irq_flag_clear(ch_irq_flag_clear), .err_flag(err_flag), .wrap_flag(wrap_flag),
		.ch_irq_flag(ch_irq_flag), .width_sel(width_sel), .count_down(count_down),
		.count_value(count_value), .buffer_transfer(buffer_transfer),
		.timer_restart(timer_restart), .timer_hard_reset(timer_hard_reset), .irq_req(irq_req));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Verdict and end of run, shared by the sequence and the watchdog
	task automatic summarize();
		if (err_total == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_strobe <= 1'b1;
		@(posedge clk);
		wr_strobe <= 1'b0;
	endtask

	// One-cycle read; data is only valid in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_strobe <= 1'b1;
		@(posedge clk);
		rd_strobe <= 1'b0;
		@(negedge clk);
		d = rd_data;
	endtask

	// One-cycle pulse on an engine input selected by k
	task automatic ev(input int k, input logic [3:0] m);
		@(posedge clk);
		case (k)
			0: at_top <= 1'b1;
			1: at_bottom <= 1'b1;
			2: per_buf_written <= 1'b1;
			3: ch_buf_written <= m;
			4: capture_event <= m;
			5: ch_irq_flag_clear <= m;
			6: count_tick <= 1'b1;
			7: qdec_index <= 1'b1;
			default: hw_dir_valid <= 1'b1;
		endcase
		@(posedge clk);
		{at_top, at_bottom, per_buf_written, count_tick, qdec_index, hw_dir_valid} <= '0;
		ch_buf_written <= '0;
		capture_event <= '0;
		ch_irq_flag_clear <= '0;
	endtask

	// Counts strobe pulses over a few cycles, so latency choices do not matter
	task automatic watch(input int n);
		nbt = '0;
		nrs = '0;
		nhr = '0;
		repeat (n) begin
			@(negedge clk);
			nbt = nbt + buffer_transfer;
			nrs = nrs + timer_restart;
			nhr = nhr + timer_hard_reset;
		end
	endtask

	// Watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		#(40 * 20000);
		err_total++;
		summarize();
	end

	// Main sequence
	initial begin
		err_total = 0;
		n_tests = 0;
		srst = 1'b1;
		{addr, wr_data, wr_strobe, rd_strobe, tc_off, capture_mode, wave_mode} = '0;
		{at_top, at_bottom, count_tick, hw_dir_valid, hw_dir, qdec_index} = '0;
		{per_buf_written, ch_buf_written, capture_event, ch_irq_flag_clear} = '0;
		{err_flag, wrap_flag, ch_irq_flag} = '0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		// Register table: reset values, field widths, set/clear ports, unmapped address
		foreach (rows[i]) begin
			if (rows[i][32]) wr(rows[i][31:24], rows[i][23:16]);
			rd(rows[i][15:8], rv);
			`CHK("reg_read", rows[i][7:0], rv)
		end
		`CHK("width_sel", 2'h2, width_sel)
		// Index flag, then split counting from zero
		ev(7, 4'h0);
		rd(OFF_F_CLR, rv);
		`CHK("index_set", 8'h10, rv)
		ev(6, 4'h0);
		repeat (3) @(negedge clk);
		`CHK("split_count", 16'h0101, count_value)
		rd(OFF_F_SET, rv);
		`CHK("index_clear", 8'h00, rv)
		wr(OFF_WIDTH, 8'h00);
		ev(6, 4'h0);
		repeat (3) @(negedge clk);
		`CHK("normal_count", 16'h0102, count_value)
		wr(OFF_WIDTH, 8'h01);
		repeat (3) @(negedge clk);
		`CHK("upper_zero", 8'h00, count_value[15:8])
		// Interrupt levels: err 11, wrap 01, D 11, C 10, B 01, A 00
		foreach (irows[i]) begin
			@(posedge clk);
			{err_flag, wrap_flag, ch_irq_flag} <= irows[i][8:3];
			repeat (3) @(negedge clk);
			`CHK("irq_req", irows[i][2:0], irq_req)
		end
		@(posedge clk);
		{err_flag, wrap_flag, ch_irq_flag} <= '0;
		// Hardware direction, then a software clear overrides it
		hw_dir <= 1'b1;
		ev(8, 4'h0);
		rd(OFF_F_SET, rv);
		`CHK("hw_dir", 8'h01, rv)
		`CHK("count_down", 1'b1, count_down)
		wr(OFF_F_CLR, 8'h01);
		rd(OFF_F_CLR, rv);
		`CHK("sw_dir", 8'h00, rv)
		// Buffer-valid events in compare and in capture operation
		wr(OFF_G_CLR, 8'h1f);
		ev(3, 4'h9);
		ev(2, 4'h0);
		rd(OFF_G_SET, rv);
		`CHK("buf_valid", 8'h13, rv)
		@(posedge clk) capture_mode <= 1'b1;
		ev(4, 4'h6);
		rd(OFF_G_CLR, rv);
		`CHK("capt_valid", 8'h1f, rv)
		ev(5, 4'h1);
		rd(OFF_G_CLR, rv);
		`CHK("flag_clear", 8'h1d, rv)
		// Lock blocks updates, except in capture operation
		wr(OFF_F_SET, 8'h02);
		ev(0, 4'h0);
		watch(4);
		`CHK("capt_lock", 4'h1, nbt)
		rd(OFF_G_CLR, rv);
		`CHK("capt_per", 8'h1c, rv)
		@(posedge clk) capture_mode <= 1'b0;
		wr(OFF_G_SET, 8'h1f);
		ev(0, 4'h0);
		watch(4);
		`CHK("locked", 4'h0, nbt)
		rd(OFF_G_SET, rv);
		`CHK("locked_valid", 8'h1f, rv)
		// PWM mode updates at BOTTOM only
		wr(OFF_F_CLR, 8'h02);
		wave_mode <= 3'h3;
		ev(0, 4'h0);
		watch(4);
		`CHK("pwm_top", 4'h0, nbt)
		ev(1, 4'h0);
		watch(4);
		`CHK("pwm_bottom", 4'h1, nbt)
		rd(OFF_G_CLR, rv);
		`CHK("update_valid", 8'h00, rv)
		// Every command code while the timer runs
		for (int c = 0; c < 4; c++) begin
			wr(OFF_F_SET, {4'h0, c[1:0], 2'b00});
			watch(4);
			`CHK("cmd_pulses", cexp[c], {nbt, nrs, nhr})
			rd(OFF_F_SET, rv);
			`CHK("cmd_reads_zero", 8'h00, rv[3:2])
		end
		// Reset in mid-run returns the registers to zero
		@(posedge clk) srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(OFF_IRQ_A, rv);
		`CHK("rst_irq_a", 8'h00, rv)
		`CHK("rst_width", 2'h0, width_sel)
		// Back-to-back set and clear of the lock bit, no gap between strobes
		@(posedge clk);
		{addr, wr_data, wr_strobe} <= {OFF_F_SET, 8'h02, 1'b1};
		@(posedge clk);
		addr <= OFF_F_CLR;
		@(posedge clk);
		wr_strobe <= 1'b0;
		rd(OFF_F_SET, rv);
		`CHK("lock_b2b", 8'h00, rv)
		// Hard reset with the timer off clears the registers and a running count
		wr(OFF_IRQ_B, 8'he4);
		ev(6, 4'h0);
		tc_off <= 1'b1;
		wr(OFF_F_SET, 8'h0c);
		watch(4);
		`CHK("hard_reset", 12'h001, {nbt, nrs, nhr})
		rd(OFF_IRQ_B, rv);
		`CHK("hr_irq_b", 8'h00, rv)
		`CHK("hr_count", 16'h0000, count_value)
		summarize();
	end
endmodule // tcf_regs_tb
